// *** core/pmsc_defs.svh ***
// Constants for the transceiver MII, strap and management block
`ifndef PMSC_DEFS_SVH
`define PMSC_DEFS_SVH

// ----------------------------------------------------------------
// Clock rates in kHz and derived half periods in system cycles
// ----------------------------------------------------------------
`define PMSC_CLK_KHZ       50000
`define PMSC_MII_FAST_KHZ  25000
`define PMSC_MII_SLOW_KHZ  2500
`define PMSC_HALF_FAST     (`PMSC_CLK_KHZ / (2 * `PMSC_MII_FAST_KHZ))
`define PMSC_HALF_SLOW     (`PMSC_CLK_KHZ / (2 * `PMSC_MII_SLOW_KHZ))

// ----------------------------------------------------------------
// Strap timing and management map
// ----------------------------------------------------------------
`define PMSC_STRAP_WAIT    3'h4
`define PMSC_REG_ID2       5'h03
`define PMSC_REG_ADVERT    5'h04
`define PMSC_MODEL_LSB     4
`define PMSC_MODEL_MSB     9
`define PMSC_ADV_SEL_W     5
`define PMSC_ADV_SEL       5'h01
`define PMSC_ADV_10H       5
`define PMSC_ADV_10F       6
`define PMSC_ADV_100H      7
`define PMSC_ADV_100F      8
`define PMSC_ADV_PAUSE     10

`endif

// *** core/pmsc_pkg.sv ***
// Types shared by the transceiver MII, strap and management block
package pmsc_pkg;
  typedef logic [4:0]  pmsc_addr_t;
  typedef logic [15:0] pmsc_word_t;
  typedef logic [3:0]  pmsc_nib_t;
  typedef enum logic [1:0] {
    PMSC_WAIT,
    PMSC_SAMPLE,
    PMSC_RUN
  } pmsc_phase_t;
endpackage

// *** core/pmsc_clk_div.sv ***
// Enable-based divider that makes the MII transmit and receive clock
`include "pmsc_defs.svh"
module pmsc_clk_div #(
  parameter int HALF_FAST = `PMSC_HALF_FAST,
  parameter int HALF_SLOW = `PMSC_HALF_SLOW
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic run,
  input  wire logic fast,
  output logic      mii_clk,
  output logic      rise,
  output logic      fall
);
  logic [7:0] cnt_reg;
  logic       fast_reg;
  logic       tick;

  function automatic logic [7:0] reload(input logic f);
    reload = f ? 8'(HALF_FAST - 1) : 8'(HALF_SLOW - 1);
  endfunction

  assign tick = run && (cnt_reg == 8'h00);
  assign rise = tick && !mii_clk;
  assign fall = tick && mii_clk;

  // Speed change restarts the count so no stretched half period
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg  <= 8'h00;
      fast_reg <= 1'h0;
    end else if (fast != fast_reg) begin
      fast_reg <= fast;
      cnt_reg  <= 8'h00;
    end else if (run) begin
      cnt_reg <= tick ? reload(fast_reg) : cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mii_clk <= 1'h0;
    end else if (tick) begin
      mii_clk <= !mii_clk;
    end
  end
endmodule

// *** core/pmsc_top.sv ***
// MAC-facing MII, strap capture, LED pins and management registers
`include "pmsc_defs.svh"
module pmsc_top #(
  parameter logic [5:0] ID_OUI_BITS = 6'h2D,  // Arbitrary value
  parameter logic [5:0] ID_MODEL    = 6'h1A,  // Arbitrary value
  parameter logic [3:0] ID_REV      = 4'h1    // Arbitrary value
) (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  output logic                      tx_clk,
  input  wire logic                 tx_en,
  input  wire pmsc_pkg::pmsc_nib_t  txd,
  output logic                      rx_clk,
  input  wire pmsc_pkg::pmsc_nib_t  rxd_pad,
  output pmsc_pkg::pmsc_nib_t       rxd_drive,
  output logic                      rxd_oe,
  output logic                      rx_er,
  output logic                      rx_dv,
  input  wire logic                 col_pad,
  output logic                      col_drive,
  output logic                      col_oe,
  input  wire logic                 led_act_pad,
  output logic                      led_act_drive,
  output logic                      led_act_oe,
  input  wire logic                 led_link_pad,
  output logic                      led_link_drive,
  output logic                      led_link_oe,
  input  wire logic                 led_speed_pad,
  output logic                      led_speed_drive,
  output logic                      led_speed_oe,
  output logic                      strap_pull_en,
  input  wire pmsc_pkg::pmsc_nib_t  line_rxd,
  input  wire logic                 line_rx_dv,
  input  wire logic                 line_rx_err,
  input  wire logic                 line_collision,
  input  wire logic                 line_activity,
  input  wire logic                 line_link_up,
  input  wire logic                 line_partner_100,
  output pmsc_pkg::pmsc_nib_t       line_txd,
  output logic                      line_tx_en,
  output logic                      line_tx_stb,
  input  wire logic                 mgmt_req,
  input  wire logic                 mgmt_wr,
  input  wire pmsc_pkg::pmsc_addr_t mgmt_phy_addr,
  input  wire pmsc_pkg::pmsc_addr_t mgmt_reg_addr,
  input  wire pmsc_pkg::pmsc_word_t mgmt_wdata,
  output pmsc_pkg::pmsc_word_t      mgmt_rdata,
  output logic                      mgmt_ack,
  output pmsc_pkg::pmsc_addr_t      station_address,
  output logic                      autoneg_on,
  output logic                      speed_100,
  output logic                      full_duplex
);
  import pmsc_pkg::*;

  // ----------------------------------------------------------------
  // Strap synchroniser and capture sequence
  // ----------------------------------------------------------------
  logic [7:0]  strap_meta_reg;
  logic [7:0]  strap_sync_reg;
  pmsc_phase_t phase_reg;
  logic [2:0]  wait_reg;
  logic        s_speed;
  logic        s_link;
  logic        s_act;
  pmsc_addr_t  s_addr;
  logic        autoneg_select_low;
  logic        autoneg_select_high;
  pmsc_word_t  autoneg_advert_register;
  logic        mii_clk;
  logic        mii_rise;
  logic        mii_fall;
  logic        running;

  assign {s_speed, s_link, s_act, s_addr} = strap_sync_reg;
  assign running = (phase_reg == PMSC_RUN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_meta_reg <= 8'h00;
      strap_sync_reg <= 8'h00;
    end else begin
      strap_meta_reg <= {led_speed_pad, led_link_pad, led_act_pad,
                         rxd_pad, col_pad};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // Wait covers the synchroniser depth so straps seen are settled pads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= PMSC_WAIT;
      wait_reg  <= 3'h0;
    end else begin
      case (phase_reg)
        PMSC_WAIT: begin
          wait_reg <= wait_reg + 3'h1;
          if (wait_reg == `PMSC_STRAP_WAIT) begin
            phase_reg <= PMSC_SAMPLE;
          end
        end
        PMSC_SAMPLE: phase_reg <= PMSC_RUN;
        PMSC_RUN:    phase_reg <= PMSC_RUN;
        default:     phase_reg <= PMSC_WAIT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      station_address     <= 5'h00;
      autoneg_on          <= 1'h0;
      autoneg_select_low  <= 1'h0;
      autoneg_select_high <= 1'h0;
    end else if (phase_reg == PMSC_SAMPLE) begin
      station_address     <= s_addr;
      autoneg_on          <= s_act;
      autoneg_select_low  <= s_link;
      autoneg_select_high <= s_speed;
    end
  end

  // Weak pulls only while the pins are still inputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_pull_en <= 1'h1;
    end else begin
      strap_pull_en <= !running && (phase_reg != PMSC_SAMPLE);
    end
  end

  // ----------------------------------------------------------------
  // Mode decode and advertisement register
  // ----------------------------------------------------------------
  function automatic pmsc_word_t adv_from_strap(input logic lo,
                                                input logic hi);
    pmsc_word_t w;
    w = {11'h000, `PMSC_ADV_SEL};
    if (!lo) begin
      w[`PMSC_ADV_10H] = 1'h1;
      w[`PMSC_ADV_10F] = 1'h1;
    end
    if (lo || hi) begin
      w[`PMSC_ADV_100H] = 1'h1;
      w[`PMSC_ADV_100F] = 1'h1;
    end
    if (lo) begin
      w[`PMSC_ADV_10H] = 1'h1;
      w[`PMSC_ADV_10F] = 1'h1;
    end
    if (!lo && hi) begin
      w[`PMSC_ADV_10H] = 1'h0;
      w[`PMSC_ADV_10F] = 1'h0;
    end
    adv_from_strap = w;
  endfunction

  function automatic logic reg_hit(input pmsc_addr_t phy,
                                   input pmsc_addr_t own,
                                   input logic       live);
    reg_hit = live && (phy == own);
  endfunction

  logic req_hit;
  assign req_hit = mgmt_req && reg_hit(mgmt_phy_addr, station_address,
                                       running);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      autoneg_advert_register <= 16'h0000;
    end else if (phase_reg == PMSC_SAMPLE) begin
      autoneg_advert_register <= adv_from_strap(s_link, s_speed);
    end else if (req_hit && mgmt_wr &&
                 mgmt_reg_addr == `PMSC_REG_ADVERT) begin
      // Pause bit only comes from here, never from a strap
      autoneg_advert_register <= {mgmt_wdata[15:`PMSC_ADV_SEL_W],
                                  `PMSC_ADV_SEL};
    end
  end

  // Forced: low select picks speed, high picks duplex
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      speed_100   <= 1'h0;
      full_duplex <= 1'h0;
    end else if (running) begin
      if (!autoneg_on) begin
        speed_100   <= autoneg_select_low;
        full_duplex <= autoneg_select_high;
      end else begin
        speed_100   <= line_partner_100 &&
                       (autoneg_advert_register[`PMSC_ADV_100H] ||
                        autoneg_advert_register[`PMSC_ADV_100F]);
        full_duplex <= speed_100 ?
                       autoneg_advert_register[`PMSC_ADV_100F] :
                       autoneg_advert_register[`PMSC_ADV_10F];
      end
    end
  end

  // ----------------------------------------------------------------
  // Management answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mgmt_ack   <= 1'h0;
      mgmt_rdata <= 16'h0000;
    end else begin
      mgmt_ack <= req_hit;
      if (req_hit && !mgmt_wr) begin
        case (mgmt_reg_addr)
          `PMSC_REG_ID2:    mgmt_rdata <= {ID_OUI_BITS, ID_MODEL,
                                           ID_REV};
          `PMSC_REG_ADVERT: mgmt_rdata <= autoneg_advert_register;
          default:          mgmt_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // MII clocks, receive and transmit paths
  // ----------------------------------------------------------------
  pmsc_clk_div u_div (
    .clk     (clk),
    .rstn    (rstn),
    .run     (running),
    .fast    (speed_100),
    .mii_clk (mii_clk),
    .rise    (mii_rise),
    .fall    (mii_fall)
  );

  // One divider feeds both clocks so they stay in phase
  assign tx_clk = mii_clk;
  assign rx_clk = mii_clk;

  // Data changes on the falling edge, MAC samples on the rising one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxd_drive <= 4'h0;
      rx_dv     <= 1'h0;
      rx_er     <= 1'h0;
    end else if (mii_fall) begin
      rxd_drive <= line_rxd;
      rx_dv     <= line_rx_dv;
      rx_er     <= line_rx_err;
    end
  end

  logic [4:0] tx_meta_reg;
  logic [4:0] tx_sync_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_meta_reg <= 5'h00;
      tx_sync_reg <= 5'h00;
    end else begin
      tx_meta_reg <= {tx_en, txd};
      tx_sync_reg <= tx_meta_reg;
    end
  end

  // Sampled at mid period; at 25 MHz this lags the MAC by one nibble
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_txd    <= 4'h0;
      line_tx_en  <= 1'h0;
      line_tx_stb <= 1'h0;
    end else begin
      line_tx_stb <= mii_fall && tx_sync_reg[4];
      if (mii_fall) begin
        line_tx_en <= tx_sync_reg[4];
        line_txd   <= tx_sync_reg[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared pins: status outputs after strap capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxd_oe          <= 1'h0;
      col_oe          <= 1'h0;
      led_act_oe      <= 1'h0;
      led_link_oe     <= 1'h0;
      led_speed_oe    <= 1'h0;
      col_drive       <= 1'h0;
      led_act_drive   <= 1'h0;
      led_link_drive  <= 1'h0;
      led_speed_drive <= 1'h0;
    end else begin
      rxd_oe          <= running;
      col_oe          <= running;
      led_act_oe      <= running;
      led_link_oe     <= running;
      led_speed_oe    <= running;
      col_drive       <= running && line_collision;
      led_act_drive   <= running && (line_activity ||
                                     line_collision);
      led_link_drive  <= running && line_link_up;
      led_speed_drive <= running && speed_100;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_own_addr: assert property (@(posedge clk) disable iff (!rstn)
    mgmt_ack |-> $past(mgmt_req) && $past(mgmt_phy_addr) ==
                 station_address)
    else $error("answer to a foreign address");
  a_no_foreign: assert property (@(posedge clk) disable iff (!rstn)
    mgmt_req && mgmt_phy_addr != station_address |=> !mgmt_ack)
    else $error("foreign access acknowledged");
  a_model_field: assert property (@(posedge clk) disable iff (!rstn)
    req_hit && !mgmt_wr && mgmt_reg_addr == `PMSC_REG_ID2 |=>
    mgmt_ack && mgmt_rdata[`PMSC_MODEL_MSB:`PMSC_MODEL_LSB] == ID_MODEL)
    else $error("model field wrong");
  a_pins_held: assert property (@(posedge clk) disable iff (!rstn)
    !running |=> !rxd_oe && !col_oe && !led_act_oe && !led_link_oe &&
                 !led_speed_oe)
    else $error("pin driven before strap capture");
  a_strap_addr: assert property (@(posedge clk) disable iff (!rstn)
    phase_reg == PMSC_SAMPLE |=> station_address == $past(s_addr) ##1
    station_address == $past(station_address))
    else $error("station address not captured");
  a_pull_off: assert property (@(posedge clk) disable iff (!rstn)
    phase_reg == PMSC_SAMPLE ##1 running |=> !strap_pull_en)
    else $error("pulls left on while driving");
  a_rx_on_fall: assert property (@(posedge clk) disable iff (!rstn)
    $changed(rxd_drive) || $changed(rx_dv) |-> $past(mii_fall))
    else $error("receive data moved off the falling edge");
  a_fast_clk: assert property (@(posedge clk) disable iff (!rstn)
    $rose(tx_clk) && speed_100 && $past(speed_100) ##1 speed_100 |->
    !tx_clk ##1 tx_clk)
    else $error("fast clock period wrong");
  a_slow_clk: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rx_clk) && !speed_100 && $past(!speed_100) ##1
    (!speed_100)[*8] |=> rx_clk ##1 !rx_clk)
    else $error("slow clock half period wrong");
  a_tx_capture: assert property (@(posedge clk) disable iff (!rstn)
    line_tx_stb |-> $past(mii_fall) && line_tx_en &&
                    line_txd == $past(tx_sync_reg[3:0]))
    else $error("transmit nibble taken off the sample point");
endmodule

// *** verification/pmsc_mac_model.sv ***
// MAC partner model for the transceiver MII
module pmsc_mac_model (
  input  wire logic                tx_clk,
  input  wire logic                rx_clk,
  input  wire pmsc_pkg::pmsc_nib_t rxd,
  input  wire logic                rx_dv,
  input  wire logic                rx_er,
  output logic                     tx_en,
  output pmsc_pkg::pmsc_nib_t      txd
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmsc_pkg::*;
  pmsc_nib_t txq[$];
  pmsc_nib_t sentq[$];
  pmsc_nib_t rx_nib;
  logic      rx_dv_seen;
  logic      rx_er_seen;
  // ------
  // Transmit side
  // ------
  // No transmit error output exists, so nothing else is driven
  initial begin
    tx_en = 1'b0;
    txd   = 4'h0;
  end
  // Emptying the queue mid frame drops enable: the far end sees a bad CRC
  always @(posedge tx_clk) begin
    if (txq.size() > 0) begin
      tx_en <= 1'b1;
      txd   <= txq[0];
      sentq.push_back(txq.pop_front());
    end else begin
      tx_en <= 1'b0;
      txd   <= ~txd;  // Idle data churns so a stale nibble never matches
    end
  end
  // ------
  // Receive side
  // ------
  always @(posedge rx_clk) begin
    rx_nib     <= rxd;
    rx_dv_seen <= rx_dv;
    rx_er_seen <= rx_er;
  end
endmodule

// *** verification/pmsc_top_tb.sv ***
// Self-checking bench for the MII, strap and management block
`include "pmsc_defs.svh"
`define CHK(nm, ex, got) \
  begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module pmsc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pmsc_pkg::*;
  localparam pmsc_word_t ID_WORD = {6'h2D, 6'h1A, 4'h1};
  // ------
  // Signals
  // ------
  logic        clk, rstn, tx_clk, rx_clk, tx_en, rxd_oe, rx_er, rx_dv;
  logic        col_drive, col_oe, led_act_drive, led_act_oe;
  logic        led_link_drive, led_link_oe, led_speed_drive, led_speed_oe;
  logic        strap_pull_en, line_rx_dv, line_rx_err, line_collision;
  logic        line_activity, line_link_up, line_partner_100, line_tx_en;
  logic        line_tx_stb, mgmt_req, mgmt_wr, mgmt_ack, autoneg_on;
  logic        speed_100, full_duplex, s_act, s_low, s_high, s_drv;
  logic        ak, an, lo, hi, a10, a100, sp, fd;
  pmsc_nib_t   txd, rxd_drive, line_rxd, line_txd, tx_exp;
  pmsc_addr_t  mgmt_phy_addr, mgmt_reg_addr, station_address, s_addr;
  pmsc_word_t  mgmt_wdata, mgmt_rdata, rd, ev;
  wire logic   col_pad, led_act_pad, led_link_pad, led_speed_pad;
  wire pmsc_nib_t rxd_pad;
  logic [31:0] lfsr_state = 32'hCE46;
  logic [31:0] r;
  int          err_total = 0;
  int          cmp_count = 0;
  int          n;
  // Pins: design drive, else strap, else weak pulls, else churn; LED pins only design drive, else strap
  assign rxd_pad = rxd_oe ? rxd_drive : s_drv ? s_addr[4:1] :
                   strap_pull_en ? 4'h0 : ~rxd_drive;
  assign col_pad = col_oe ? col_drive : s_drv ? s_addr[0] :
                   strap_pull_en ? 1'b1 : ~col_drive;
  assign led_act_pad   = led_act_oe ? led_act_drive : s_act;
  assign led_link_pad  = led_link_oe ? led_link_drive : s_low;
  assign led_speed_pad = led_speed_oe ? led_speed_drive : s_high;

  pmsc_top DUT (.*);
  pmsc_mac_model mac (
    .tx_clk (tx_clk),
    .rx_clk (rx_clk),
    .rxd    (rxd_drive),
    .rx_dv  (rx_dv),
    .rx_er  (rx_er),
    .tx_en  (tx_en),
    .txd    (txd)
  );
  // ------
  // Tasks
  // ------
  function automatic void rnd(output logic [31:0] v);
    lfsr_state = {lfsr_state[30:0],
                  lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^
                  lfsr_state[0]};
    v = lfsr_state;
  endfunction
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic do_reset(input logic a, l, h, d, input pmsc_addr_t ad);
    @(posedge clk);
    rstn   <= 1'b0;
    s_act  <= a;
    s_low  <= l;
    s_high <= h;
    s_drv  <= d;
    s_addr <= ad;
    repeat (3) @(posedge clk);
    #1;
    `CHK("pull_in_reset", 1'b1, strap_pull_en)
    `CHK("oe_in_reset", 1'b0, rxd_oe | led_act_oe | col_oe | led_link_oe | led_speed_oe)
    `CHK("clk_in_reset", 1'b0, tx_clk)
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (12) @(posedge clk);
    #1;
    `CHK("pull_released", 1'b0, strap_pull_en)
    `CHK("oe_running", 1'b1, rxd_oe & led_link_oe & led_speed_oe & led_act_oe & col_oe)
  endtask
  // Management access; answer sampled one cycle after it is taken
  task automatic mg(input logic wr, input pmsc_addr_t pa, ra,
                    input pmsc_word_t wd, output logic k,
                    output pmsc_word_t d);
    @(posedge clk);
    mgmt_req      <= 1'b1;
    mgmt_wr       <= wr;
    mgmt_phy_addr <= pa;
    mgmt_reg_addr <= ra;
    mgmt_wdata    <= wd;
    @(posedge clk);
    mgmt_req <= 1'b0;
    #1;
    k = mgmt_ack;
    d = mgmt_rdata;
  endtask
  task automatic period(output int p);
    realtime t0;
    @(posedge tx_clk);
    t0 = $realtime;
    @(posedge tx_clk);
    p = int'(($realtime - t0) / 20.0);
    #1;
    `CHK("rx_clk_equal", tx_clk, rx_clk)
  endtask
  // ------
  // Monitor, clock, watchdog
  // ------
  always @(posedge clk) begin
    if (line_tx_stb === 1'b1) begin
      `CHK("nibble_pending", 1'b1, mac.sentq.size() > 0)
      tx_exp = (mac.sentq.size() > 0) ? mac.sentq.pop_front() : ~line_txd;
      `CHK("line_txd", tx_exp, line_txd)
      `CHK("line_tx_en", 1'b1, line_tx_en)
    end
  end
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    err_total++;
    $display("Watchdog expired");
    give_verdict();
  end
  // ------
  // Scenarios
  // ------
  initial begin
    {rstn, mgmt_req, mgmt_wr, mgmt_phy_addr, mgmt_reg_addr} = '0;
    {mgmt_wdata, line_rxd, line_rx_dv, line_rx_err} = '0;
    {line_collision, line_activity, line_link_up, line_partner_100} = '0;
    {s_act, s_low, s_high, s_drv, s_addr} = '0;
    for (int m = 0; m < 8; m++) begin
      rnd(r);
      @(posedge clk);
      line_partner_100 <= r[0];
      do_reset(m[2], m[1], m[0], 1'b0, 5'h00);
      {an, lo, hi} = m[2:0];
      a100 = lo | hi;
      a10  = lo | ~hi;
      sp   = an ? (r[0] & a100) : lo;
      fd   = an ? (sp ? a100 : a10) : hi;
      `CHK("station_address", 5'h01, station_address)
      `CHK("autoneg_on", an, autoneg_on)
      `CHK("speed_100", sp, speed_100)
      `CHK("full_duplex", fd, full_duplex)
      if (an) begin
        ev = 16'h0001 | (a10 ? 16'h0060 : 16'h0000) |
             (a100 ? 16'h0180 : 16'h0000);
        mg(1'b0, 5'h01, `PMSC_REG_ADVERT, 16'h0000, ak, rd);
        `CHK("advert", ev, rd)
      end
      period(n);
      `CHK("period", sp ? 2 * `PMSC_HALF_FAST : 2 * `PMSC_HALF_SLOW, n)
    end
    $display("Test straps done");
    do_reset(1'b0, 1'b1, 1'b1, 1'b1, 5'h14);
    `CHK("strapped_address", 5'h14, station_address)
    mg(1'b0, 5'h01, `PMSC_REG_ID2, 16'h0000, ak, rd);
    `CHK("foreign_ack", 1'b0, ak)
    mg(1'b0, 5'h14, `PMSC_REG_ID2, 16'h0000, ak, rd);
    `CHK("own_ack", 1'b1, ak)
    `CHK("id_word", ID_WORD, rd)
    `CHK("model", 6'h1A, rd[9:4])
    rnd(r);
    mg(1'b1, 5'h14, `PMSC_REG_ID2, r[15:0], ak, rd);
    mg(1'b0, 5'h14, `PMSC_REG_ID2, 16'h0000, ak, rd);
    `CHK("id_readonly", ID_WORD, rd)
    mg(1'b1, 5'h14, `PMSC_REG_ADVERT, r[15:0] | 16'h0400, ak, rd);
    mg(1'b0, 5'h14, `PMSC_REG_ADVERT, 16'h0000, ak, rd);
    `CHK("advert_pause", {r[15:11], 1'b1, r[9:5], 5'h01}, rd)
    mg(1'b0, 5'h14, 5'h05, 16'h0000, ak, rd);
    `CHK("unmapped", 16'h0000, rd)
    $display("Test management done");
    for (int i = 0; i < 6; i++) begin
      rnd(r);
      @(posedge rx_clk);
      @(posedge clk);
      line_rxd       <= r[3:0];
      line_rx_dv     <= r[4];
      line_rx_err    <= r[5];
      line_activity  <= r[6];
      line_collision <= r[7];
      line_link_up   <= r[8];
      repeat (2) @(posedge rx_clk);
      #1;
      `CHK("rxd", r[3:0], mac.rx_nib)
      `CHK("rx_dv", r[4], mac.rx_dv_seen)
      `CHK("rx_er", r[5], mac.rx_er_seen)
      `CHK("led_act", r[6] | r[7], led_act_drive)
      `CHK("led_link", r[8], led_link_drive)
      `CHK("led_speed", 1'b1, led_speed_drive)
      `CHK("col", r[7], col_drive)
    end
    $display("Test receive and status done");
    for (int i = 0; i < 8; i++) begin
      rnd(r);
      mac.txq.push_back(r[3:0]);
    end
    repeat (60) @(posedge clk);
    #1;
    `CHK("fast_frame_out", 0, mac.sentq.size())
    `CHK("fast_idle", 1'b0, line_tx_en)
    do_reset(1'b0, 1'b0, 1'b0, 1'b0, 5'h00);
    for (int i = 0; i < 12; i++) begin
      rnd(r);
      mac.txq.push_back(r[3:0]);
    end
    repeat (3) @(posedge tx_clk);
    mac.txq.delete();
    repeat (120) @(posedge clk);
    #1;
    `CHK("cut_frame_out", 0, mac.sentq.size())
    `CHK("cut_idle", 1'b0, line_tx_en)
    $display("Test transmit done");
    give_verdict();
  end
endmodule
